// File: rtl/serial_channel_pkg.sv
// Constants, field groups and carrier types for the clock-synchronous serial channel.
// Assumes one system clock domain; link pins are sampled inside the channel itself.
package serial_channel_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Character framing and bit positions.
  localparam int unsigned CHAR_BITS = 8;
  localparam logic [3:0] POS_FIRST = 4'h0;
  localparam logic [3:0] POS_LAST = 4'h7;
  localparam logic [3:0] POS_DONE = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset and idle levels.
  localparam logic TXD_IDLE = 1'h1;
  localparam logic SCK_IDLE = 1'h1;
  localparam logic TX_EMPTY_RST = 1'h1;
  localparam logic TX_COMPLETE_RST = 1'h1;
  localparam logic FLAG_RST = 1'h0;
  localparam logic [7:0] CHAR_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Internal serial clock: system clock cycles per half period of the serial clock.
  localparam int unsigned SCK_HALF_DEFAULT = 4;

  typedef logic [CHAR_BITS-1:0] char_t;

  // Static configuration, written by software.
  typedef struct packed {
    logic tx_enable;
    logic rx_enable;
    logic clk_internal;
    logic tx_empty_irq_en;
    logic tx_complete_irq_en;
    logic rx_irq_en;
  } ctrl_t;

  // One-cycle strobes from the processor or a transfer engine.
  typedef struct packed {
    logic tx_wr;
    logic dma_tx_wr;
    char_t tx_data;
    logic tx_empty_clr;
    logic tx_complete_clr;
    logic rx_full_clr;
    logic dma_rx_rd;
    logic overrun_clr;
    logic framing_clr;
    logic parity_clr;
    logic framing_set;
    logic parity_set;
  } host_cmd_t;

  // Status seen by software.
  typedef struct packed {
    logic tx_empty_flag;
    logic tx_complete_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_fault_flag;
    logic parity_fault_flag;
    char_t rx_holding_reg;
  } status_t;

  typedef struct packed {
    logic tx_empty_irq;
    logic tx_complete_irq;
    logic rx_full_irq;
    logic rx_fault_irq;
  } irq_t;

endpackage

// File: rtl/sync_serial_txrx.sv
// Clock-synchronous transmit and receive path of one serial channel.
// Assumes host strobes come from logic on clock; the serial clock and data-in pins
// are asynchronous and pass two flip-flops before use.
`timescale 1ns/100ps

module sync_serial_txrx
  import serial_channel_pkg::*;
#(
  parameter int unsigned SCK_HALF_CYCLES = SCK_HALF_DEFAULT
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Software configuration and host strobes
  input wire ctrl_t ctrl,
  input wire host_cmd_t cmd,
  // Status and requests
  output status_t status,
  output irq_t irq,
  // Serial clock pin, three signals
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  // Serial data
  input wire logic rxd,
  output logic txd
);

  localparam int unsigned HALF_W = (SCK_HALF_CYCLES > 1) ? $clog2(SCK_HALF_CYCLES) : 1;
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(SCK_HALF_CYCLES - 1);

  logic sck_meta, sck_sync, sck_prev, rxd_meta, rxd_sync;
  logic [HALF_W-1:0] gen_cnt;
  logic gen_run;
  logic int_fall, int_rise, fall_ev, rise_ev;
  logic halt;
  logic tx_run_ok;
  logic rx_run;
  logic tx_active;
  logic [3:0] tx_pos;
  logic reload_due;
  char_t tx_holding_reg;
  char_t tx_shifter;
  logic tx_empty_flag;
  logic tx_complete_flag;
  logic tx_start, tx_fall, tx_end, tx_reload;
  logic [3:0] rx_pos;
  char_t rx_shifter;
  char_t next_rx_shifter;
  char_t rx_holding_reg;
  logic rx_full_flag;
  logic rx_done;
  logic rx_free;
  logic overrun_flag;
  logic framing_fault_flag;
  logic parity_fault_flag;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and external edge detection.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      sck_meta <= SCK_IDLE;
      sck_sync <= SCK_IDLE;
      sck_prev <= SCK_IDLE;
      rxd_meta <= TXD_IDLE;
      rxd_sync <= TXD_IDLE;
    end
    else
    begin
      sck_meta <= sck_in;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Internal serial clock. Unless a fault stands, it runs while the transmitter has a frame or the receiver
  // is enabled, so the pin rests high between characters only when transmitting alone;
  // an enabled receiver alone keeps it running, which is why a single-character receive
  // wants the external clock.
  assign halt = overrun_flag | framing_fault_flag | parity_fault_flag;
  assign tx_run_ok = ctrl.tx_enable & ~halt;
  assign rx_run = ctrl.rx_enable & ~halt;
  assign gen_run = ctrl.clk_internal & ((tx_active & tx_run_ok) | rx_run);

  always_ff @(posedge clock)
  begin
    if (sys_rst || !gen_run)
    begin
      gen_cnt <= '0;
      sck_out <= SCK_IDLE;
    end
    else if (gen_cnt == HALF_LAST)
    begin
      gen_cnt <= '0;
      sck_out <= ~sck_out;
    end
    else
    begin
      gen_cnt <= gen_cnt + 1'h1;
    end
  end

  assign int_fall = gen_run & (gen_cnt == HALF_LAST) & sck_out;
  assign int_rise = gen_run & (gen_cnt == HALF_LAST) & ~sck_out;
  assign sck_oe_n = ~ctrl.clk_internal;
  assign fall_ev = ctrl.clk_internal ? int_fall : (sck_prev & ~sck_sync);
  assign rise_ev = ctrl.clk_internal ? int_rise : (~sck_prev & sck_sync);

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  assign tx_start = tx_run_ok & ~tx_active & ~tx_empty_flag;
  assign tx_fall = tx_run_ok & tx_active & fall_ev & (tx_pos != POS_DONE);
  assign tx_end = tx_run_ok & tx_active & rise_ev & (tx_pos == POS_DONE);
  assign tx_reload = tx_end & reload_due;

  always_ff @(posedge clock)
  begin
    if (sys_rst || !ctrl.tx_enable)
    begin
      tx_active <= 1'h0;
      tx_pos <= POS_FIRST;
      reload_due <= 1'h0;
      tx_shifter <= CHAR_RST;
    end
    else if (tx_start || tx_reload)
    begin
      tx_active <= 1'h1;
      tx_pos <= POS_FIRST;
      reload_due <= 1'h0;
      tx_shifter <= tx_holding_reg;
    end
    else if (tx_end)
    begin
      tx_active <= 1'h0;
    end
    else if (tx_fall)
    begin
      tx_pos <= tx_pos + 4'h1;
      if (tx_pos == POS_LAST)
      begin
        reload_due <= ~tx_empty_flag;
      end
    end
  end

  // The output keeps the last bit's level once the frame ends.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      txd <= TXD_IDLE;
    end
    else if (tx_fall)
    begin
      txd <= tx_shifter[tx_pos[2:0]];
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_holding_reg <= CHAR_RST;
    end
    else if (cmd.tx_wr || cmd.dma_tx_wr)
    begin
      tx_holding_reg <= cmd.tx_data;
    end
  end

  // A load in the same cycle as a clear wins, so no character is sent twice.
  always_ff @(posedge clock)
  begin
    if (sys_rst || !ctrl.tx_enable)
    begin
      tx_empty_flag <= TX_EMPTY_RST;
    end
    else if (tx_start || tx_reload)
    begin
      tx_empty_flag <= 1'h1;
    end
    else if (cmd.tx_empty_clr || cmd.dma_tx_wr)
    begin
      tx_empty_flag <= 1'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      tx_complete_flag <= TX_COMPLETE_RST;
    end
    else if (tx_fall && tx_pos == POS_LAST && tx_empty_flag)
    begin
      tx_complete_flag <= 1'h1;
    end
    else if (tx_start || cmd.tx_complete_clr)
    begin
      tx_complete_flag <= 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver.
  assign next_rx_shifter = {rxd_sync, rx_shifter[CHAR_BITS-1:1]};
  assign rx_done = rx_run & rise_ev & (rx_pos == POS_LAST);
  assign rx_free = ~rx_full_flag | cmd.rx_full_clr | cmd.dma_rx_rd;

  // Disabling keeps the shifter, the holding register and every flag.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_pos <= POS_FIRST;
      rx_shifter <= CHAR_RST;
    end
    else if (!ctrl.rx_enable)
    begin
      rx_pos <= POS_FIRST;
    end
    else if (rx_run && rise_ev)
    begin
      rx_shifter <= next_rx_shifter;
      rx_pos <= rx_done ? POS_FIRST : rx_pos + 4'h1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_holding_reg <= CHAR_RST;
    end
    else if (rx_done && rx_free)
    begin
      rx_holding_reg <= next_rx_shifter;
    end
  end

  // Faults stop rx_run, so a character can never complete while one stands.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      rx_full_flag <= FLAG_RST;
    end
    else if (rx_done && rx_free)
    begin
      rx_full_flag <= 1'h1;
    end
    else if (cmd.rx_full_clr || cmd.dma_rx_rd)
    begin
      rx_full_flag <= 1'h0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      overrun_flag <= FLAG_RST;
    end
    else if (rx_done && !rx_free)
    begin
      overrun_flag <= 1'h1;
    end
    else if (cmd.overrun_clr)
    begin
      overrun_flag <= 1'h0;
    end
  end

  // Framing and parity faults are carried over from the asynchronous formats.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      framing_fault_flag <= FLAG_RST;
      parity_fault_flag <= FLAG_RST;
    end
    else
    begin
      framing_fault_flag <= cmd.framing_set | (framing_fault_flag & ~cmd.framing_clr);
      parity_fault_flag <= cmd.parity_set | (parity_fault_flag & ~cmd.parity_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status and requests.
  assign status = '{
    tx_empty_flag: tx_empty_flag,
    tx_complete_flag: tx_complete_flag,
    rx_full_flag: rx_full_flag,
    overrun_flag: overrun_flag,
    framing_fault_flag: framing_fault_flag,
    parity_fault_flag: parity_fault_flag,
    rx_holding_reg: rx_holding_reg
  };

  assign irq.tx_empty_irq = tx_empty_flag & ctrl.tx_empty_irq_en;
  assign irq.tx_complete_irq = tx_complete_flag & ctrl.tx_complete_irq_en;
  assign irq.rx_full_irq = rx_full_flag & ctrl.rx_irq_en;
  assign irq.rx_fault_irq = halt & ctrl.rx_irq_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking chk_clk @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_load_sets_empty: assert property (tx_start |=>
    tx_empty_flag && tx_active && tx_pos == POS_FIRST)
    else $error("load did not set transmit-empty");
  a_bit_order: assert property (tx_fall |=> txd == $past(tx_shifter[tx_pos[2:0]]))
    else $error("wrong bit placed on serial output");
  a_sck_rests_high: assert property (!gen_run |=> sck_out)
    else $error("serial clock not high while idle");
  a_fault_blocks: assert property (halt |-> !tx_start && !rx_done)
    else $error("transfer proceeded under a fault");
  a_no_full_on_fault: assert property ((framing_fault_flag || parity_fault_flag) |=>
    !$rose(rx_full_flag))
    else $error("receive-full set while a fault stands");
  a_overrun_on_full: assert property (rx_done && !rx_free |=>
    overrun_flag && $stable(rx_holding_reg))
    else $error("overrun not flagged or data overwritten");
  a_store_on_free: assert property (rx_done && rx_free |=>
    rx_full_flag && rx_holding_reg == $past(next_rx_shifter))
    else $error("received character not stored");
  a_complete_at_msb: assert property (tx_fall && tx_pos == POS_LAST && tx_empty_flag |=>
    tx_complete_flag ##1 !tx_reload)
    else $error("transmit-complete not set at last bit");
  a_disable_empties: assert property (!ctrl.tx_enable |=> tx_empty_flag && !tx_active)
    else $error("transmit disable did not reset the transmitter");
  a_engine_read: assert property (cmd.dma_rx_rd && !rx_done |=> !rx_full_flag)
    else $error("engine read did not clear receive-full");
  a_fault_irq: assert property (overrun_flag && ctrl.rx_irq_en |-> irq.rx_fault_irq)
    else $error("receive-error request missing");
endmodule

// File: sim/serial_peer.sv
// Model of the external clock-synchronous device that shares the serial clock.
// Assumes the bench resolves the clock pin and hands it back as sck_pin.
`timescale 1ns/100ps

module serial_peer (
  // Link pins seen by the peer
  input wire logic sck_pin,
  input wire logic txd,
  // Lines the peer drives
  output logic sck_drv,
  output logic rxd
);
  logic [7:0] got;
  int rises;

  initial
  begin
    sck_drv = 1'h1;
    rxd = 1'h1;
    got = 8'h00;
    rises = 0;
  end

  // Samples on every rising edge of the pin, whoever drives it.
  always @(posedge sck_pin)
  begin
    got <= {txd, got[7:1]};
    rises <= rises + 1;
  end

  // One character at 160 ns per bit; the clock rests high between frames.
  task automatic xfer(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      sck_drv = 1'h0;
      rxd = d[i];
      #80;
      sck_drv = 1'h1;
      #80;
    end
    // Released line shows the inverse so a stale sample cannot pass.
    rxd = ~d[7];
  endtask
endmodule

// File: sim/sync_serial_txrx_tb.sv
// Self-checking bench: host strobes drive the channel, a peer model works the link.
// Assumes the package and the peer model are compiled first.
`timescale 1ns/100ps

module sync_serial_txrx_tb;
  import serial_channel_pkg::*;
  logic clock = 1'h0;
  logic sys_rst = 1'h1;
  ctrl_t ctrl = '0;
  host_cmd_t cmd = '0;
  status_t status;
  irq_t irq;
  logic sck_out, sck_oe_n, txd, rxd, peer_sck, sck_pin;
  int bad_count = 0;
  int total_checks = 0;
  int r0;

  always #4 clock = ~clock;
  assign sck_pin = sck_oe_n ? peer_sck : sck_out;

  sync_serial_txrx #(.SCK_HALF_CYCLES(4)) uut (
    .clock(clock), .sys_rst(sys_rst), .ctrl(ctrl), .cmd(cmd), .status(status),
    .irq(irq), .sck_in(sck_pin), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .rxd(rxd), .txd(txd));
  serial_peer peer (.sck_pin(sck_pin), .txd(txd), .sck_drv(peer_sck), .rxd(rxd));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk8(input char_t got, input char_t exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // One-cycle strobe: 0 tx_wr, 1 dma_tx_wr, 2 tx_empty_clr, 3 rx_full_clr,
  // 4 dma_rx_rd, 5 overrun_clr, 6 parity_set, 7 parity_clr, 8 tx_complete_clr,
  // 9 framing_set, 10 framing_clr.
  task automatic hit(input int k, input char_t d);
    host_cmd_t c;
    c = '0;
    c.tx_data = d;
    case (k)
      0: c.tx_wr = 1'h1;
      1: c.dma_tx_wr = 1'h1;
      2: c.tx_empty_clr = 1'h1;
      3: c.rx_full_clr = 1'h1;
      4: c.dma_rx_rd = 1'h1;
      5: c.overrun_clr = 1'h1;
      6: c.parity_set = 1'h1;
      7: c.parity_clr = 1'h1;
      8: c.tx_complete_clr = 1'h1;
      9: c.framing_set = 1'h1;
      default: c.framing_clr = 1'h1;
    endcase
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    cmd <= '0;
  endtask

  // Waits for 0 tx_complete, 1 rx_full, 2 overrun.
  task automatic wait_bit(input int k);
    logic v;
    for (int i = 0; i < 3000; i++)
    begin
      @(posedge clock);
      #1;
      v = (k == 0) ? status.tx_complete_flag :
          (k == 1) ? status.rx_full_flag : status.overrun_flag;
      if (v === 1'h1)
        return;
    end
    bad_count++;
    stop_test();
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'h0;
    settle(1);
    chk1(sck_out, 1'h1);
    chk1(txd, 1'h1);
    chk1(status.tx_empty_flag, 1'h1);
    // Internal clock, transmit only, both transmit requests enabled.
    @(posedge clock);
    ctrl <= 6'h2e;
    r0 = peer.rises;
    hit(0, 8'ha5);
    hit(2, 8'h00);
    settle(2);
    chk1(status.tx_empty_flag, 1'h1);
    chk1(irq.tx_empty_irq, 1'h1);
    chk1(status.tx_complete_flag, 1'h0);
    chk1(sck_oe_n, 1'h0);
    wait_bit(0);
    settle(8);
    chk8(peer.got, 8'ha5);
    chk8(8'(peer.rises - r0), 8'h08);
    chk1(sck_out, 1'h1);
    chk1(txd, 1'h1);
    chk1(irq.tx_complete_irq, 1'h1);
    hit(8, 8'h00);
    settle(1);
    chk1(status.tx_complete_flag, 1'h0);
    chk1(irq.tx_complete_irq, 1'h0);
    // Engine writes back to back: the second byte follows with no gap.
    r0 = peer.rises;
    hit(1, 8'h3c);
    hit(1, 8'hc3);
    wait_bit(0);
    settle(8);
    chk8(peer.got, 8'hc3);
    chk8(8'(peer.rises - r0), 8'h10);
    // Full duplex on the external clock; enables cleared together, then set together.
    chk1(status.overrun_flag, 1'h0);
    @(posedge clock);
    ctrl <= 6'h00;
    @(posedge clock);
    ctrl <= 6'h37;
    hit(1, 8'h5a);
    settle(6);
    peer.xfer(8'h96);
    wait_bit(1);
    chk8(status.rx_holding_reg, 8'h96);
    chk1(irq.rx_full_irq, 1'h1);
    chk1(sck_oe_n, 1'h1);
    chk8(peer.got, 8'h5a);
    chk1(txd, 1'h0);
    chk1(status.tx_complete_flag, 1'h1);
    // Second character while full: overrun, data discarded, all halted.
    peer.xfer(8'h11);
    wait_bit(2);
    chk8(status.rx_holding_reg, 8'h96);
    chk1(irq.rx_fault_irq, 1'h1);
    hit(3, 8'h00);
    peer.xfer(8'h22);
    settle(8);
    chk1(status.rx_full_flag, 1'h0);
    hit(5, 8'h00);
    peer.xfer(8'h44);
    wait_bit(1);
    chk8(status.rx_holding_reg, 8'h44);
    hit(4, 8'h00);
    settle(1);
    chk1(status.rx_full_flag, 1'h0);
    // Leftover parity and framing faults block both directions.
    hit(6, 8'h00);
    hit(9, 8'h00);
    hit(0, 8'h77);
    hit(2, 8'h00);
    peer.xfer(8'h66);
    settle(8);
    chk1(status.tx_empty_flag, 1'h0);
    chk1(status.rx_full_flag, 1'h0);
    @(posedge clock);
    ctrl <= 6'h00;
    settle(3);
    chk1(status.tx_empty_flag, 1'h1);
    chk8(status.rx_holding_reg, 8'h44);
    chk1(status.framing_fault_flag, 1'h1);
    hit(7, 8'h00);
    hit(10, 8'h00);
    settle(1);
    chk1(status.parity_fault_flag, 1'h0);
    chk1(status.framing_fault_flag, 1'h0);
    // Receiver disabled: a frame on the link is ignored.
    peer.xfer(8'h55);
    settle(8);
    chk1(status.rx_full_flag, 1'h0);
    chk8(status.rx_holding_reg, 8'h44);
    stop_test();
  end
endmodule
